// [design/sdmb_params.svh]
// Purpose: constants of the mode configuration and burst sequencer
// Assumes: 100 MHz system clock
// Notes:   field positions, encodings and widths
`ifndef SDMB_PARAMS_SVH
`define SDMB_PARAMS_SVH
`define SDMB_CFG_W          13
`define SDMB_BL_LSB         0
`define SDMB_BL_MSB         2
`define SDMB_ORDER_BIT      3
`define SDMB_LAT_LSB        4
`define SDMB_LAT_MSB        6
`define SDMB_OPM_LSB        7
`define SDMB_OPM_MSB        8
`define SDMB_WB_BIT         9
`define SDMB_BL_1           3'h0
`define SDMB_BL_2           3'h1
`define SDMB_BL_4           3'h2
`define SDMB_BL_8           3'h3
`define SDMB_BL_PAGE        3'h7
`define SDMB_LAT_2          3'h2
`define SDMB_LAT_3          3'h3
`define SDMB_OPM_NORMAL     2'h0
`define SDMB_CFG_RESET      13'h0000
`endif

// [design/sdmb_pkg.sv]
// Purpose: types of the mode configuration and burst sequencer
// Assumes: nothing
// Notes:   command codes as decoded by the block's own port
package sdmb_pkg;
  typedef enum logic [2:0] {
    SDMB_CMD_NOP,
    SDMB_CMD_LOAD_MODE,
    SDMB_CMD_READ,
    SDMB_CMD_WRITE,
    SDMB_CMD_TERMINATE
  } sdmb_cmd_e;
  typedef enum logic [1:0] {
    SDMB_IDLE,
    SDMB_READ_BURST,
    SDMB_WRITE_BURST
  } sdmb_state_e;
endpackage

// [design/sdmb_burst_seq.sv]
// Purpose: mode configuration word and burst column sequencing
// Assumes: commands arrive already decoded, on clk, from logic in the same domain
// Notes:   configuration has no functional reset value in the device
//
// Operation
// R1: Configuration word holds until the next mode-load command overwrites it.
// R2: Bits 0-2 length, 3 order, 4-6 latency, 7-8 mode, 9 write-burst.
// R3: Controller drives address bit 12 low; device ignores it.
// R4: Mode-load only with all banks idle, then wait before next command.
// R5: Lengths 1,2,4,8 in both orders; full page sequential only.
// R6: Full-page burst stops on the burst-terminate command.
// R7: Lengths 2,4,8 wrap within aligned block chosen by upper column bits.
// R8: Full page spans 1,024 columns, starts at column, wraps at page end.
// R9: Order bit selects sequential or interleaved ordering for bursts of length 2, 4 and 8.
// R10: Sequential counts up modulo length; interleaved is start XOR count.
// R11: Length one accesses only the given column; order bit ignored.
// R12: Read latency programmable to two or three clocks.
// R13: Data driven from edge n+m-1, valid by edge n+m.
// R14: Controller never programs reserved field encodings; the bench loads latency code 1 once to check cfgReserved.
// R15: Normal operation needs both mode bits zero; others not programmed.
// R16: Write-burst bit one makes writes single column; reads keep length.
// R17: Address bits 0-11 carry the configuration word on mode-load.
// R18: Length codes 0,1,2,3,7; latency codes 2,3; others reserved.
`timescale 1ns/1ps
`include "sdmb_params.svh"
module sdmb_burst_seq #(
  parameter int COL_W = 10
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Decoded command and address
  input  wire sdmb_pkg::sdmb_cmd_e cmd,
  input  wire logic [12:0]        addr,
  // Column sequence
  output logic                    colValid,
  output logic [COL_W-1:0]        colAddr,
  output logic                    colIsWrite,
  // Read data timing
  output logic                    dqDriveEn,
  output logic                    dqValid,
  // Configuration view
  output logic [`SDMB_CFG_W-1:0]  burstModeConfig,
  output logic                    cfgReserved
);

  // ==========================================================
  // Configuration register
  logic [`SDMB_CFG_W-1:0] cfg_q;
  wire  isLoad = (cmd == sdmb_pkg::SDMB_CMD_LOAD_MODE);
  wire  isRead = (cmd == sdmb_pkg::SDMB_CMD_READ);
  wire  isWrite = (cmd == sdmb_pkg::SDMB_CMD_WRITE);
  wire  isTerm = (cmd == sdmb_pkg::SDMB_CMD_TERMINATE);

  // Reset only gives simulation a known word; the memory powers up undefined
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= `SDMB_CFG_RESET;
    end else if (isLoad) begin
      cfg_q <= {1'b0, addr[11:0]}; // [R1] [R17] [R3]
    end
  end
  assign burstModeConfig = cfg_q;

  // ==========================================================
  // Field decode
  wire [2:0] burstLenField    = cfg_q[`SDMB_BL_MSB:`SDMB_BL_LSB]; // [R2]
  wire       burstOrderBit    = cfg_q[`SDMB_ORDER_BIT];
  wire [2:0] readLatencyField = cfg_q[`SDMB_LAT_MSB:`SDMB_LAT_LSB];
  wire [1:0] opMode           = cfg_q[`SDMB_OPM_MSB:`SDMB_OPM_LSB];
  wire       writeBurstBit    = cfg_q[`SDMB_WB_BIT];

  // One named wire per legal code
  wire isBl1  = (burstLenField == `SDMB_BL_1);
  wire isBl2  = (burstLenField == `SDMB_BL_2);
  wire isBl4  = (burstLenField == `SDMB_BL_4);
  wire isBl8  = (burstLenField == `SDMB_BL_8);
  wire isPage = (burstLenField == `SDMB_BL_PAGE);
  wire isLat2 = (readLatencyField == `SDMB_LAT_2);
  wire isLat3 = (readLatencyField == `SDMB_LAT_3);
  wire modeOk = (opMode == `SDMB_OPM_NORMAL); // [R15]
  // Interleaved full page is not a supported setting
  wire lenOk  = isBl1 || isBl2 || isBl4 || isBl8 || (isPage && !burstOrderBit); // [R5] [R18]
  wire latOk  = isLat2 || isLat3;
  // Flag only; behaviour with reserved codes is undefined anyway
  assign cfgReserved = !lenOk || !latOk || !modeOk; // [R14] [R15]

  // Column mask of the wrapping block; page mask covers all columns
  logic [COL_W-1:0] lenMask;
  always_comb begin
    case (burstLenField)
      `SDMB_BL_2:    lenMask = COL_W'(1); // [R7]
      `SDMB_BL_4:    lenMask = COL_W'(3);
      `SDMB_BL_8:    lenMask = COL_W'(7);
      `SDMB_BL_PAGE: lenMask = '1; // [R8]
      default:       lenMask = '0; // [R11]
    endcase
  end
  // Write-burst bit forces single-column writes
  wire [COL_W-1:0] maskForCmd = (isWrite && writeBurstBit) ? '0 : lenMask; // [R16]

  // ==========================================================
  // Burst sequencer
  sdmb_pkg::sdmb_state_e state_q, state_d, newState;
  logic [COL_W-1:0]      start_q, start_d, cnt_q, cnt_d, mask_q, mask_d;
  logic                  inter_q, inter_d, page_q, page_d;

  wire startBurst = isRead || isWrite;
  wire lastBeat   = !page_q && (cnt_q == mask_q);
  // Interleave means nothing for one column; full page runs sequential only
  wire newInter   = burstOrderBit && (maskForCmd != '0) && !isPage; // [R11] [R5]
  wire newPage    = isPage && (maskForCmd != '0);
  assign newState = isRead ? sdmb_pkg::SDMB_READ_BURST : sdmb_pkg::SDMB_WRITE_BURST;

  // ==========================================================
  // Column of the current beat, one bit at a time
  // Bits above the block keep the start column; bits inside follow the count
  // Mask is contiguous from bit 0, so the carry never leaves the block
  wire [COL_W-1:0] seqSum = COL_W'(start_q + cnt_q); // [R10]
  wire [COL_W-1:0] curCol;
  genvar colBit;
  generate
    for (colBit = 0; colBit < COL_W; colBit++) begin : g_colBit
      wire inBlock = mask_q[colBit]; // [R7] [R8]
      wire seqBit  = seqSum[colBit];
      wire intBit  = start_q[colBit] ^ cnt_q[colBit];
      assign curCol[colBit] = inBlock ? (inter_q ? intBit : seqBit) : start_q[colBit]; // [R9]
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    start_d = start_q;
    cnt_d   = cnt_q;
    mask_d  = mask_q;
    inter_d = inter_q;
    page_d  = page_q;
    case (state_q)
      // Idle waits for a column command
      sdmb_pkg::SDMB_IDLE: begin
        if (startBurst) begin
          state_d = newState;
          start_d = addr[COL_W-1:0];
          cnt_d   = '0;
          mask_d  = maskForCmd;
          inter_d = newInter;
          page_d  = newPage;
        end
      end
      sdmb_pkg::SDMB_READ_BURST,
      sdmb_pkg::SDMB_WRITE_BURST: begin
        if (startBurst) begin
          // A new column command truncates any burst in flight
          state_d = newState;
          start_d = addr[COL_W-1:0];
          cnt_d   = '0;
          mask_d  = maskForCmd;
          inter_d = newInter;
          page_d  = newPage;
        end else if (isTerm) begin
          state_d = sdmb_pkg::SDMB_IDLE; // [R6]
        end else if (lastBeat) begin
          state_d = sdmb_pkg::SDMB_IDLE;
        end else begin
          cnt_d = cnt_q + COL_W'(1); // [R8]
        end
      end
      // Unused encodings fall back to idle
      default: begin
        state_d = sdmb_pkg::SDMB_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers; cleared only so simulation starts known
  // Burst state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sdmb_pkg::SDMB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Start column, captured with the command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= '0;
    end else begin
      start_q <= start_d;
    end
  end

  // Beat count within the burst
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Wrap mask; zero means a single column
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Interleaved order for this burst
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inter_q <= 1'b0;
    end else begin
      inter_q <= inter_d;
    end
  end

  // Full page runs until stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= 1'b0;
    end else begin
      page_q <= page_d;
    end
  end

  // ==========================================================
  // Column outputs, registered
  // Beat present
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      colValid <= 1'b0;
    end else begin
      colValid <= (state_q != sdmb_pkg::SDMB_IDLE);
    end
  end

  // Column of the beat
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      colAddr <= '0;
    end else begin
      colAddr <= curCol;
    end
  end

  // Write beat marker
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      colIsWrite <= 1'b0;
    end else begin
      colIsWrite <= (state_q == sdmb_pkg::SDMB_WRITE_BURST);
    end
  end

  // ==========================================================
  // Read latency pipeline
  // Slot k holds the read beat of k+1 cycles ago
  logic [1:0] rdPipe_q;
  wire        rdBeat = (state_q == sdmb_pkg::SDMB_READ_BURST);
  // Shift of read beats
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPipe_q <= '0;
    end else begin
      rdPipe_q <= {rdPipe_q[0], rdBeat};
    end
  end

  // Beat 0 is in state from the edge that takes the command, edge n
  // Latency three delays both outputs by one more slot
  wire lat3 = isLat3; // [R12]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dqDriveEn <= 1'b0;
    end else begin
      dqDriveEn <= lat3 ? rdPipe_q[0] : rdBeat; // [R13]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dqValid <= 1'b0;
    end else begin
      dqValid <= lat3 ? rdPipe_q[1] : rdPipe_q[0]; // [R13]
    end
  end

endmodule

// [tb/sdmb_burst_seq_props.sv]
// Purpose: port assertions of the burst sequencer
// Assumes: one clock domain
// Notes:   bound from the bench file
`timescale 1ns/1ps
`include "sdmb_params.svh"
module sdmb_burst_seq_props #(parameter int COL_W = 10) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // Command
  input wire sdmb_pkg::sdmb_cmd_e cmd,
  input wire logic [12:0]         addr,
  // Watched outputs
  input wire logic                colValid,
  input wire logic [COL_W-1:0]    colAddr,
  input wire logic                dqDriveEn,
  input wire logic                dqValid,
  input wire logic [12:0]         burstModeConfig
);
  // ==========
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic [2:0] latF = burstModeConfig[6:4];
  wire logic       bl4s = burstModeConfig[3:0] == {1'b0, `SDMB_BL_4};
  wire logic       rd   = cmd == sdmb_pkg::SDMB_CMD_READ;
  wire logic       ld   = cmd == sdmb_pkg::SDMB_CMD_LOAD_MODE;
  wire logic       wr   = cmd == sdmb_pkg::SDMB_CMD_WRITE;
  sequence oneBeat; colValid ##1 !colValid; endsequence
  sequence lateDrive; !dqDriveEn ##1 dqDriveEn; endsequence
  cfg_hold_a: assert property (!ld |=> $stable(burstModeConfig))
    else $error("cfg moved");
  cfg_load_a: assert property (ld |=> burstModeConfig == {1'b0, $past(addr[11:0])})
    else $error("cfg load");
  first_beat_a: assert property (rd |-> ##2 colValid && colAddr == $past(addr[9:0], 2))
    else $error("first beat");
  lat_two_a: assert property (rd && latF == `SDMB_LAT_2 |-> ##2 dqDriveEn)
    else $error("lat two");
  lat_three_a: assert property (rd && latF == `SDMB_LAT_3 |-> ##2 lateDrive)
    else $error("lat three");
  data_valid_a: assert property ($rose(dqDriveEn) |=> dqValid)
    else $error("dq valid");
  seq_wrap_a: assert property (colValid && bl4s ##1 colValid |->
    colAddr == {$past(colAddr[9:2]), $past(colAddr[1:0]) + 2'h1}) else $error("seq wrap");
  wr_single_a: assert property (wr && burstModeConfig[9] |-> ##2 oneBeat)
    else $error("write single");
  term_stop_a: assert property (cmd == sdmb_pkg::SDMB_CMD_TERMINATE |-> ##2 !colValid)
    else $error("terminate");
endmodule

// [tb/sdmb_ctrl_model.sv]
// Purpose: memory controller issuing decoded commands
// Assumes: issue is called at a falling edge
// Notes:   released address moves so stale values never pass
`timescale 1ns/1ps
module sdmb_ctrl_model (
  // Clock
  input  wire logic          clk,
  // Command
  output sdmb_pkg::sdmb_cmd_e cmd,
  output logic [12:0]        addr
);
  // ==========
  // Issue
  initial begin
    cmd  = sdmb_pkg::SDMB_CMD_NOP;
    addr = 13'h0000;
  end
  task automatic issue(input sdmb_pkg::sdmb_cmd_e c, input logic [12:0] a);
    cmd  = c;
    addr = (c == sdmb_pkg::SDMB_CMD_LOAD_MODE) ? {1'b0, a[11:0]} : a;
    @(negedge clk);
    cmd  = sdmb_pkg::SDMB_CMD_NOP;
    addr = ~addr;
  endtask
endmodule

// [tb/sdmb_burst_seq_bench.sv]
// Purpose: self-checking bench of the burst sequencer
// Assumes: stimulus at falling edges
// Notes:   beats checked in order from a queue
`timescale 1ns/1ps
`include "sdmb_params.svh"
module sdmb_burst_seq_bench;
  // ==========
  // Signals
  localparam sdmb_pkg::sdmb_cmd_e RD = sdmb_pkg::SDMB_CMD_READ;
  localparam sdmb_pkg::sdmb_cmd_e WR = sdmb_pkg::SDMB_CMD_WRITE;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  sdmb_pkg::sdmb_cmd_e cmd;
  logic [12:0]         addr, cfg;
  logic [9:0]          colAddr;
  logic                colValid, colIsWrite, dqDriveEn, dqValid, cfgReserved;
  logic [10:0]         expQ[$];
  int                  errTotal = 0, checkCount = 0, seed = 72243;
  always #5 clk = ~clk;
  sdmb_ctrl_model ctrl_u (.clk, .cmd, .addr);
  sdmb_burst_seq dut_u (.clk, .arst_n, .cmd, .addr, .colValid, .colAddr, .colIsWrite,
    .dqDriveEn, .dqValid, .burstModeConfig(cfg), .cfgReserved);
  task automatic tally(input string n, input logic [13:0] e, s);
    checkCount++;
    if (e !== s) begin
      errTotal++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic check_col(input logic [10:0] e);
    tally("column", {3'h0, e}, {3'h0, colIsWrite, colAddr});
  endtask
  task automatic check_cfg(input logic [12:0] e, input logic r);
    tally("config", {r, e}, {cfgReserved, cfg});
  endtask
  function automatic logic [9:0] col(input logic [9:0] s, k, input logic [2:0] b, input logic o);
    logic [9:0] m;
    m = (b == `SDMB_BL_PAGE) ? 10'h3ff : (10'h001 << b) - 10'h001;
    return (s & ~m) | ((o ? s ^ k : s + k) & m);
  endfunction
  always @(negedge clk) if (colValid === 1'b1) check_col(expQ.size() ? expQ.pop_front() : 'x);
  // ==========
  // Scenarios
  task automatic run(input logic [11:0] w, input sdmb_pkg::sdmb_cmd_e c, input int n);
    logic [9:0] s;
    logic       one;
    s   = 10'($random(seed));
    one = w[2:0] == `SDMB_BL_1 || (c == WR && w[9]);
    ctrl_u.issue(sdmb_pkg::SDMB_CMD_LOAD_MODE, {1'b1, w});
    repeat (3) @(negedge clk); // Idle gap after a load
    check_cfg({1'b0, w}, !(w[6:4] inside {`SDMB_LAT_2, `SDMB_LAT_3}));
    for (int k = 0; k < (one ? 1 : n); k++)
      expQ.push_back({c == WR, col(s, 10'(k), one ? 3'h0 : w[2:0], w[3])});
    ctrl_u.issue(c, {3'h0, s});
    if (w[2:0] == `SDMB_BL_PAGE) begin
      repeat (n - 1) @(negedge clk);
      ctrl_u.issue(sdmb_pkg::SDMB_CMD_TERMINATE, 13'h0000); // Arbitrary length
    end
    repeat (14) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errTotal, checkCount);
    if (errTotal == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    run(12'h021, RD, 2); // Normal mode codes only
    run(12'h03a, RD, 4); // Interleaved, latency three
    run(12'h033, RD, 8);
    run(12'h02b, RD, 8);
    run(12'h038, RD, 1); // Order ignored
    run(12'h027, RD, 12); // Full page
    run(12'h232, WR, 4);
    run(12'h022, WR, 4);
    run(12'h013, sdmb_pkg::SDMB_CMD_NOP, 0); // Reserved latency flagged
    tally("leftover", 14'h0000, 14'(expQ.size()));
    end_sim;
  end
  initial begin
    #20000;
    errTotal++;
    end_sim;
  end
endmodule
bind sdmb_burst_seq sdmb_burst_seq_props #(.COL_W(COL_W)) chk_u (.clk, .arst_n, .cmd, .addr,
  .colValid, .colAddr, .dqDriveEn, .dqValid, .burstModeConfig);
